// *** vrc_regs.vh ***
// Offsets, field positions and reset values of the second channel registers
`ifndef VRC_REGS_VH
`define VRC_REGS_VH

`define VRC_ADDR_W          12
`define VRC_CAP_OFFSET      12'h16C
`define VRC_CTL_OFFSET      12'h170
`define VRC_STAT_OFFSET     12'h174
`define VRC_STAT_SHIFT      16

`define VRC_EN_BIT          31
`define VRC_ID_HI           26
`define VRC_ID_LO           24
`define VRC_SEL_HI          19
`define VRC_SEL_LO          17
`define VRC_LOAD_BIT        16
`define VRC_MAP_HI          7
`define VRC_MAP_LO          0

`define VRC_PEND_BIT        1
`define VRC_TBL_BIT         0

`define VRC_CTL_RESET       32'h01000000
`define VRC_EN_RESET        1'h0
`define VRC_ID_RESET        3'h1
`define VRC_SEL_RESET       3'h0
`define VRC_MAP_RESET       8'h00
`define VRC_MAP_RO_MASK     8'hFE

`define VRC_SEL_ROUND_ROBIN 3'h0
`define VRC_SEL_TIME_WRR    3'h4
`define VRC_CAP_VALUE       32'h077F0011

`endif

// *** vrc_resource_control.v ***
// Control and status registers of the second virtual channel
//
// Summary of operation
// [RL1] Writing one to bit 31 starts negotiation and sets pending; resets 0.
// [RL2] Channel identifier bits 26:24 read/write, reset to 001b.
// [RL3] Software never writes identifier 000b; that belongs to channel zero.
// [RL4] Scheme select bits 19:17 read/write; index into capability bits.
// [RL5] Select 000 is round-robin and reset; 100 is time-based WRR.
// [RL6] Software writes only select 000 or 100; others are reserved.
// [RL7] Writing one to bit 16 loads staged table into working tables.
// [RL8] Load bit is self-clearing and always reads zero.
// [RL9] Map bit one means that traffic class uses this channel.
// [RL10] Map bit 0 is read-only zero; class zero never maps here.
// [RL11] Class map resets to 00h.
// [RL12] Reserved bits 30:27, 23:20, 15:8 read zero.
// [RL13] Whole control register resets to 0100 0000h.
// [RL14] Pending flag stays set while enable negotiation is in progress.
// [RL15] Table status flag clears when a requested refresh completes.
// [RL16] Capability field reads 11h: round-robin and time-based WRR.
// [RL17] Writes change only read/write fields of the control register.

`include "vrc_regs.vh"

module vrc_resource_control
(
    input  wire        clock,
    input  wire        rst,
    input  wire        ce,
    input  wire        cfg_wr,
    input  wire        cfg_rd,
    input  wire [11:0] cfg_addr,
    input  wire [31:0] cfg_wdata,
    input  wire [3:0]  cfg_be,
    input  wire        neg_done,
    input  wire        table_modified,
    input  wire        table_load_done,
    output wire [31:0] cfg_rdata,
    output wire        cfg_rvalid,
    output wire        second_channel_enable,
    output wire [2:0]  channel_identifier,
    output wire [2:0]  port_scheme_select,
    output wire [7:0]  class_to_channel_map,
    output wire        negotiation_pending_flag,
    output wire        table_status_flag,
    output wire        neg_start,
    output wire        table_load
);

    localparam NEG_IDLE  = 1'b0;
    localparam NEG_BUSY  = 1'b1;
    localparam LOAD_IDLE = 1'b0;
    localparam LOAD_BUSY = 1'b1;

    reg        en_ff;
    reg [2:0]  id_ff;
    reg [2:0]  sel_ff;
    reg [7:0]  map_ff;
    reg        pend_ff;
    reg        tbl_ff;
    reg        neg_st_ff;
    reg        load_st_ff;
    reg        neg_start_ff;
    reg        table_load_ff;
    reg [31:0] rdata_ff;
    reg        rvalid_ff;

    reg        nxt_en;
    reg [2:0]  nxt_id;
    reg [2:0]  nxt_sel;
    reg [7:0]  nxt_map;
    reg        nxt_pend;
    reg        nxt_tbl;
    reg        nxt_neg_st;
    reg        nxt_load_st;
    reg        nxt_neg_start;
    reg        nxt_table_load;
    reg [31:0] nxt_rdata;
    reg        nxt_rvalid;

    wire        ctl_wr;
    wire        en_wr_one;
    wire        load_wr_one;
    wire [31:0] ctl_view;
    wire [31:0] stat_view;

    assign ctl_wr      = cfg_wr && (cfg_addr == `VRC_CTL_OFFSET);
    assign en_wr_one   = ctl_wr && cfg_be[3] && cfg_wdata[`VRC_EN_BIT];
    assign load_wr_one = ctl_wr && cfg_be[2] && cfg_wdata[`VRC_LOAD_BIT];

    // Reserved bits and the load trigger are built as constant zeros
    assign ctl_view = {en_ff,
                       4'h0,                       // RL12
                       id_ff,
                       4'h0,                       // RL12
                       sel_ff,
                       1'b0,                       // RL8
                       8'h00,                      // RL12
                       map_ff[7:1],
                       1'b0};                      // RL10

    // Status sits in the upper half of its dword
    assign stat_view = {14'h0000,
                        pend_ff,
                        tbl_ff,
                        16'h0000};

    // Control register fields
    always @*
    begin
        nxt_en  = en_ff;
        nxt_id  = id_ff;
        nxt_sel = sel_ff;
        nxt_map = map_ff;
        if (ctl_wr)
        begin
            if (cfg_be[3])
            begin
                nxt_en = cfg_wdata[`VRC_EN_BIT];                        // RL1
                // Stored as written; identifier zero is left to software
                nxt_id = cfg_wdata[`VRC_ID_HI:`VRC_ID_LO];              // RL2
            end
            if (cfg_be[2])
            begin
                // Unsupported encodings are kept, not coerced
                nxt_sel = cfg_wdata[`VRC_SEL_HI:`VRC_SEL_LO];           // RL4
            end
            if (cfg_be[0])
            begin
                nxt_map = cfg_wdata[`VRC_MAP_HI:`VRC_MAP_LO]
                          & `VRC_MAP_RO_MASK;                           // RL10
            end
        end
    end                                                                 // RL17

    // Negotiation sequence
    always @*
    begin
        nxt_neg_st    = neg_st_ff;
        nxt_pend      = pend_ff;
        nxt_neg_start = 1'b0;
        case (neg_st_ff)
            NEG_IDLE:
            begin
                if (en_wr_one)
                begin
                    nxt_neg_start = 1'b1;                               // RL1
                    nxt_pend      = 1'b1;                               // RL1
                    nxt_neg_st    = NEG_BUSY;
                end
            end
            NEG_BUSY:
            begin
                // A fresh enable in the completion cycle restarts, set wins
                if (en_wr_one)
                begin
                    nxt_neg_start = 1'b1;
                    nxt_pend      = 1'b1;                               // RL14
                end
                else if (neg_done)
                begin
                    nxt_pend   = 1'b0;                                  // RL14
                    nxt_neg_st = NEG_IDLE;
                end
            end
            default:
            begin
                nxt_neg_st = NEG_IDLE;
                nxt_pend   = 1'b0;
            end
        endcase
    end

    // Table load sequence and table status flag
    always @*
    begin
        nxt_load_st    = load_st_ff;
        nxt_tbl        = tbl_ff;
        nxt_table_load = 1'b0;
        case (load_st_ff)
            LOAD_IDLE:
            begin
                if (load_wr_one)
                begin
                    nxt_table_load = 1'b1;                              // RL7
                    nxt_load_st    = LOAD_BUSY;
                end
            end
            LOAD_BUSY:
            begin
                // A second trigger during a load is absorbed by it
                if (table_load_done)
                begin
                    nxt_tbl     = 1'b0;                                 // RL15
                    nxt_load_st = LOAD_IDLE;
                end
            end
            default:
            begin
                nxt_load_st = LOAD_IDLE;
            end
        endcase
        // A table edit in the clearing cycle keeps the flag set
        if (table_modified)
        begin
            nxt_tbl = 1'b1;
        end
    end

    // Read data, answered one cycle after the request
    always @*
    begin
        nxt_rvalid = cfg_rd;
        nxt_rdata  = 32'h00000000;
        if (cfg_rd)
        begin
            case (cfg_addr)
                `VRC_CAP_OFFSET:  nxt_rdata = `VRC_CAP_VALUE;           // RL16
                `VRC_CTL_OFFSET:  nxt_rdata = ctl_view;
                `VRC_STAT_OFFSET: nxt_rdata = stat_view;
                default:          nxt_rdata = 32'h00000000;
            endcase
        end
    end

    // Control fields; ce low freezes them with the rest of the state
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            en_ff  <= `VRC_EN_RESET;                                    // RL13
            id_ff  <= `VRC_ID_RESET;                                    // RL2
            sel_ff <= `VRC_SEL_RESET;                                   // RL5
            map_ff <= `VRC_MAP_RESET;                                   // RL11
        end
        else if (ce)
        begin
            en_ff  <= nxt_en;
            id_ff  <= nxt_id;
            sel_ff <= nxt_sel;
            map_ff <= nxt_map;
        end
    end

    // Negotiation state, pending flag and start pulse
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            neg_st_ff    <= NEG_IDLE;
            pend_ff      <= 1'b0;
            neg_start_ff <= 1'b0;
        end
        else if (ce)
        begin
            neg_st_ff    <= nxt_neg_st;
            pend_ff      <= nxt_pend;
            neg_start_ff <= nxt_neg_start;
        end
    end

    // Table load state, table flag and load pulse
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            load_st_ff    <= LOAD_IDLE;
            tbl_ff        <= 1'b0;
            table_load_ff <= 1'b0;
        end
        else if (ce)
        begin
            load_st_ff    <= nxt_load_st;
            tbl_ff        <= nxt_tbl;
            table_load_ff <= nxt_table_load;                            // RL8
        end
    end

    // Read path; a frozen clock enable also holds the last answer
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rdata_ff  <= 32'h00000000;
            rvalid_ff <= 1'b0;
        end
        else if (ce)
        begin
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    assign cfg_rdata                = rdata_ff;
    assign cfg_rvalid               = rvalid_ff;
    assign second_channel_enable    = en_ff;
    assign channel_identifier       = id_ff;
    assign port_scheme_select       = sel_ff;                           // RL5
    assign class_to_channel_map     = map_ff;                           // RL9
    assign negotiation_pending_flag = pend_ff;
    assign table_status_flag        = tbl_ff;
    assign neg_start                = neg_start_ff;
    assign table_load               = table_load_ff;

endmodule // vrc_resource_control

// *** vrc_monitor.sv ***
// Port assertions for the second channel control registers
`include "vrc_regs.vh"
module vrc_monitor
(
    input wire        clock,
    input wire        rst,
    input wire        ce,
    input wire        cfg_wr,
    input wire        cfg_rd,
    input wire [11:0] cfg_addr,
    input wire [31:0] cfg_wdata,
    input wire [3:0]  cfg_be,
    input wire        neg_done,
    input wire        table_modified,
    input wire        table_load_done,
    input wire [31:0] cfg_rdata,
    input wire        cfg_rvalid,
    input wire        second_channel_enable,
    input wire [2:0]  channel_identifier,
    input wire [2:0]  port_scheme_select,
    input wire [7:0]  class_to_channel_map,
    input wire        negotiation_pending_flag,
    input wire        table_status_flag,
    input wire        neg_start,
    input wire        table_load
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy_ff;
    wire  wr_ctl = ce && cfg_wr && cfg_addr == `VRC_CTL_OFFSET;
    wire  en_wr = wr_ctl && cfg_be[3] && cfg_wdata[31];
    // Completion only counts while a requested load is outstanding
    always @(posedge clock or posedge rst)
        if (rst)
            busy_ff <= 1'b0;
        else if (ce)
            busy_ff <= table_load | (busy_ff & ~table_load_done);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_map_zero: assert property (class_to_channel_map[0] == 1'b0)
        else $error("class zero mapped");
    a_en_start: assert property (en_wr |=> neg_start
        && second_channel_enable && negotiation_pending_flag)
        else $error("enable write did not start negotiation");
    a_load_cause: assert property ($rose(table_load)
        |-> $past(wr_ctl && cfg_be[2] && cfg_wdata[16]))
        else $error("load pulse without load write");
    a_pend_hold: assert property (negotiation_pending_flag
        && !neg_done |=> negotiation_pending_flag)
        else $error("pending dropped early");
    a_pend_clear: assert property (negotiation_pending_flag
        && ce && neg_done && !en_wr |=> !negotiation_pending_flag)
        else $error("pending not cleared");
    a_tbl_clear: assert property (ce && busy_ff && table_load_done
        && !table_modified |=> !table_status_flag)
        else $error("table flag not cleared");
    a_id_write: assert property (wr_ctl && cfg_be[3]
        |=> channel_identifier == $past(cfg_wdata[26:24]))
        else $error("identifier not written");
    a_sel_write: assert property (wr_ctl && cfg_be[2]
        |=> port_scheme_select == $past(cfg_wdata[19:17]))
        else $error("scheme select not written");
    a_fields_hold: assert property (!wr_ctl |=> $stable(channel_identifier)
        && $stable(port_scheme_select) && $stable(class_to_channel_map))
        else $error("field changed without write");
    a_zero_bits: assert property (cfg_rvalid
        && $past(cfg_addr) == `VRC_CTL_OFFSET
        |-> (cfg_rdata & 32'h78F1FF01) == 32'h0)
        else $error("reserved or load bit read nonzero");
endmodule // vrc_monitor

bind vrc_resource_control vrc_monitor i_mon (.*);

// *** vrc_resource_control_tb_top.sv ***
// Self-checking bench of the second channel control registers
`include "vrc_regs.vh"
module vrc_resource_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] ctl_off = `VRC_CTL_OFFSET;
    localparam logic [11:0] sta_off = `VRC_STAT_OFFSET;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        cfg_wr = 1'b0;
    logic        cfg_rd = 1'b0;
    logic [11:0] cfg_addr = 12'h000;
    logic [31:0] cfg_wdata = 32'h0;
    logic [3:0]  cfg_be = 4'h0;
    logic        neg_done = 1'b0;
    logic        table_modified = 1'b0;
    logic        table_load_done = 1'b0;
    logic [31:0] cfg_rdata;
    logic        cfg_rvalid;
    logic        neg_start;
    logic        table_load;
    logic        second_channel_enable;
    logic [2:0]  channel_identifier;
    logic [2:0]  port_scheme_select;
    logic [7:0]  class_to_channel_map;
    logic        negotiation_pending_flag;
    logic        table_status_flag;
    logic [31:0] rnd_d;
    wire  [31:0] fields_seen = {second_channel_enable, 4'h0,
                                channel_identifier, 4'h0,
                                port_scheme_select, 9'h000,
                                class_to_channel_map};
    wire  [31:0] flags_seen = {30'h0, negotiation_pending_flag,
                               table_status_flag};
    logic [31:0] ctl_m = `VRC_CTL_RESET;
    logic [31:0] lfsr = 32'hBF49;
    logic        pend_m = 1'b0;
    logic        tbl_m = 1'b0;
    logic        busy_m = 1'b0;
    int          bad_count = 0;
    int          total_checks = 0;

    vrc_resource_control i_dut
    (
        .clock                    (clock),
        .rst                      (rst),
        .ce                       (ce),
        .cfg_wr                   (cfg_wr),
        .cfg_rd                   (cfg_rd),
        .cfg_addr                 (cfg_addr),
        .cfg_wdata                (cfg_wdata),
        .cfg_be                   (cfg_be),
        .neg_done                 (neg_done),
        .table_modified           (table_modified),
        .table_load_done          (table_load_done),
        .cfg_rdata                (cfg_rdata),
        .cfg_rvalid               (cfg_rvalid),
        .second_channel_enable    (second_channel_enable),
        .channel_identifier       (channel_identifier),
        .port_scheme_select       (port_scheme_select),
        .class_to_channel_map     (class_to_channel_map),
        .negotiation_pending_flag (negotiation_pending_flag),
        .table_status_flag        (table_status_flag),
        .neg_start                (neg_start),
        .table_load               (table_load)
    );

    always #4 clock = ~clock;

    function automatic logic [31:0] nxt_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, got);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic step();
        @(posedge clock);
        #1;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        cfg_rd = 1'b1;
        cfg_addr = a;
        step();
        cfg_rd = 1'b0;
        chk("rvalid", 32'h1, {31'h0, cfg_rvalid});
        chk("rdata", exp, cfg_rdata);
        step();
    endtask

    // Only the control dword holds writable bits; other places ignore it
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] be);
        logic [3:0]  eb;
        logic [31:0] m;
        logic        ld;
        eb = (a == ctl_off) ? be : 4'h0;
        m = {{8{eb[3]}}, {8{eb[2]}}, {8{eb[1]}}, {8{eb[0]}}} & 32'h870E00FE;
        ld = eb[2] & d[16] & !busy_m;
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_wdata = d;
        cfg_be = be;
        step();
        cfg_wr = 1'b0;
        ctl_m = (ctl_m & ~m) | (d & m);
        pend_m = pend_m | (eb[3] & d[31]);
        busy_m = busy_m | ld;
        chk("start", {31'h0, eb[3] & d[31]}, {31'h0, neg_start});
        chk("load", {31'h0, ld}, {31'h0, table_load});
        chk("fields", ctl_m, fields_seen);
        step();
    endtask

    task automatic side(input logic nd, tm, ld);
        neg_done = nd;
        table_modified = tm;
        table_load_done = ld;
        step();
        neg_done = 1'b0;
        table_modified = 1'b0;
        table_load_done = 1'b0;
        pend_m = pend_m & !nd;
        tbl_m = tm | (tbl_m & !(ld & busy_m));
        busy_m = busy_m & !ld;
        chk("flags", {30'h0, pend_m, tbl_m}, flags_seen);
        rd(sta_off, {14'h0, pend_m, tbl_m, 16'h0});
    endtask

    initial
    begin
        repeat (10) @(posedge clock);
        #1;
        rst = 1'b0;
        rd(ctl_off, `VRC_CTL_RESET);
        rd(`VRC_CAP_OFFSET, `VRC_CAP_VALUE);
        rd(12'h200, 32'h0);
        wr(12'h200, 32'hFFFFFFFF, 4'hF);
        wr(sta_off, 32'hFFFFFFFF, 4'hF);
        rd(ctl_off, ctl_m);
        for (int i = 1; i >= 0; i--)
        begin
            wr(ctl_off, {5'h0, i ? 3'h7 : 3'h1, 4'h0, 3'(4 * i), 17'h0}, 4'hC);
            rd(ctl_off, ctl_m);
        end
        // A write offered while the clock enable is low must not be taken
        ce = 1'b0;
        cfg_wr = 1'b1;
        cfg_addr = ctl_off;
        cfg_wdata = 32'h870900FE;
        cfg_be = 4'hF;
        step();
        step();
        cfg_wr = 1'b0;
        ce = 1'b1;
        chk("frozen", 32'h0, {30'h0, neg_start, table_load});
        rd(ctl_off, ctl_m);
        repeat (30)
        begin
            lfsr = nxt_rand(lfsr);
            rnd_d = lfsr;
            rnd_d[26:24] = (lfsr[26:24] == 3'h0) ? 3'h1 : lfsr[26:24];
            rnd_d[19:17] = lfsr[17] ? `VRC_SEL_TIME_WRR
                                    : `VRC_SEL_ROUND_ROBIN;
            wr(ctl_off, rnd_d, lfsr[11:8]);
            side(lfsr[12], lfsr[13], 1'b0);
            rd(ctl_off, ctl_m);
        end
        side(1'b0, 1'b0, busy_m);
        side(1'b0, 1'b1, 1'b0);
        wr(ctl_off, 32'h00010000, 4'h4);
        wr(ctl_off, 32'h00010000, 4'h4);
        side(1'b0, 1'b1, 1'b1);
        wr(ctl_off, 32'h00010000, 4'h4);
        side(1'b0, 1'b0, 1'b1);
        wr(ctl_off, 32'h80000000, 4'h8);
        side(1'b1, 1'b0, 1'b0);
        wr(ctl_off, 32'h80000000, 4'h8);
        rst = 1'b1;
        step();
        rst = 1'b0;
        ctl_m = `VRC_CTL_RESET;
        pend_m = 1'b0;
        tbl_m = 1'b0;
        busy_m = 1'b0;
        rd(ctl_off, `VRC_CTL_RESET);
        rd(sta_off, 32'h0);
        chk("fields", ctl_m, fields_seen);
        report_and_stop();
    end

    initial
    begin
        repeat (100000) @(posedge clock);
        bad_count++;
        report_and_stop();
    end
endmodule // vrc_resource_control_tb_top
